// [emb_pkg.sv]
`default_nettype none
package emb_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [15:0] CLK_DIV_IDX   = 16'h1c26;
  localparam logic [15:0] LANE_CTL_IDX  = 16'h1c33;
  localparam logic [31:0] CLK_DIV_ADDR  = {14'h0000, CLK_DIV_IDX, 2'h0};
  localparam logic [31:0] LANE_CTL_ADDR = {14'h0000, LANE_CTL_IDX, 2'h0};

  // Field positions and reset values.
  localparam int         DIV_SEL_BIT   = 0;
  localparam int         LANE_SEL_LSB  = 0;
  localparam logic       DIV_SEL_RST   = 1'h1;
  localparam logic [1:0] LANE_SEL_RST  = 2'h0;

  // Byte-lane select encodings.
  localparam logic [1:0] LANE_WORD     = 2'h0;
  localparam logic [1:0] LANE_HIGH     = 2'h1;
  localparam logic [1:0] LANE_LOW      = 2'h2;
  localparam logic [1:0] LANE_RSVD     = 2'h3;

  // External bus width encodings.
  localparam logic [1:0] BUS_W8        = 2'h0;
  localparam logic [1:0] BUS_W16       = 2'h1;

  // Byte enables for the three usable lane settings.
  localparam logic [1:0] BE_BOTH       = 2'h3;
  localparam logic [1:0] BE_HIGH       = 2'h2;
  localparam logic [1:0] BE_LOW        = 2'h1;

  // Access sequencer states.
  typedef enum logic [0:0] {
    EMB_IDLE  = 1'b0,
    EMB_ISSUE = 1'b1
  } emb_seq_t;

  // Complete state of the top module.
  typedef struct packed {
    logic        hready;
    logic [31:0] hrdata;
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic        div_sel;
    logic [1:0]  lane_sel;
    logic        div_applied;
    emb_seq_t    st;
    logic        narrow;
    logic        two_step;
    logic        acc_req;
    logic        acc_we;
    logic        acc_reg;
    logic [1:0]  acc_be;
    logic        acc_hi;
    logic [15:0] acc_wdata;
    logic [15:0] low_wdata;
    logic [15:0] rdata;
    logic        ready;
    logic        done;
  } emb_state_t;

  // Complete state of the clock enable divider.
  typedef struct packed {
    logic en;
  } emb_div_state_t;

endpackage
`default_nettype wire

// [emb_clk_div.sv]
`timescale 1ns/10ps
`default_nettype none
module emb_clk_div (
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // Rate select, high for full rate.
  input  wire logic full_rate_i,
  // Interface clock enable.
  output logic      en_o
);

  emb_pkg::emb_div_state_t s_q;
  emb_pkg::emb_div_state_t s_d;

  // Full rate holds the enable high; half rate alternates it, so every
  // enable pulse is a whole cycle and no pulse is ever cut short.
  always_comb begin
    s_d = s_q;
    if (full_rate_i) begin
      s_d.en = 1'b1;
    end else begin
      s_d.en = ~s_q.en;
    end
  end

  // State register; reset starts with the enable high.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q.en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign en_o = s_q.en;

endmodule
`default_nettype wire

// [emb_ctrl.sv]
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module emb_ctrl (
  // Clock and reset.
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic             hreadyout_o,
  output logic [31:0]      hrdata_o,
  output logic             hresp_o,
  // Processor word access port.
  input  wire logic        cpu_req_i,
  input  wire logic        cpu_is_reg_i,
  input  wire logic        cpu_we_i,
  input  wire logic [15:0] cpu_wdata_i,
  output logic             cpu_ready_o,
  output logic             cpu_done_o,
  output logic [15:0]      cpu_rdata_o,
  // Bus width setting of the memory interface.
  input  wire logic [1:0]  external_bus_width_i,
  // Access towards the memory interface engines.
  output logic             acc_req_o,
  output logic             acc_we_o,
  output logic             acc_reg_o,
  output logic [1:0]       acc_be_o,
  output logic             acc_hi_o,
  output logic [15:0]      acc_wdata_o,
  input  wire logic        acc_ack_i,
  input  wire logic [15:0] acc_rdata_i,
  // Interface clock enable and applied rate.
  output logic             mem_clk_en_o,
  output logic             full_rate_o
);

  emb_pkg::emb_state_t s_q;
  emb_pkg::emb_state_t s_d;
  logic [1:0]          mode;
  logic                narrow;
  logic [1:0]          be;
  logic [15:0]         mask;
  logic                take;

  // Address phase is taken on a selected, ready, active transfer.
  assign take = hsel_i & hready_i & htrans_i[1];

  // Lane settings for a new processor access.
  always_comb begin
    mode   = s_q.lane_sel;
    // Only external memory on a byte-wide bus needs the byte steps.
    narrow = ~cpu_is_reg_i & (external_bus_width_i == emb_pkg::BUS_W8);
    case (mode)
      emb_pkg::LANE_HIGH: be = emb_pkg::BE_HIGH;
      emb_pkg::LANE_LOW:  be = emb_pkg::BE_LOW;
      default:            be = emb_pkg::BE_BOTH;
    endcase
    // Byte mask that zeroes the lane which is not selected.
    mask = {{8{be[1]}}, {8{be[0]}}};
  end

  // Register file, bus slave and access sequencer.
  always_comb begin
    s_d      = s_q;
    // The done pulse lasts one cycle unless it is set again below.
    s_d.done = 1'b0;
    // Data phase of a write lands here; reserved bits are dropped.
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == emb_pkg::CLK_DIV_ADDR) begin
        s_d.div_sel = hwdata_i[emb_pkg::DIV_SEL_BIT];
      end else if (s_q.wr_addr == emb_pkg::LANE_CTL_ADDR &&
                   hwdata_i[emb_pkg::LANE_SEL_LSB +: 2] !=
                   emb_pkg::LANE_RSVD) begin
        s_d.lane_sel = hwdata_i[emb_pkg::LANE_SEL_LSB +: 2];
      end
    end
    // A write occupies exactly one data phase, so the flag never lingers.
    s_d.wr_pend = 1'b0;
    // Address phase; read data reflects a write finishing this cycle.
    if (take) begin
      s_d.wr_pend = hwrite_i;
      s_d.wr_addr = haddr_i;
      s_d.hrdata  = 32'h00000000;
      if (!hwrite_i) begin
        if (haddr_i == emb_pkg::CLK_DIV_ADDR) begin
          s_d.hrdata = {31'h00000000, s_d.div_sel};
        end else if (haddr_i == emb_pkg::LANE_CTL_ADDR) begin
          s_d.hrdata = {30'h00000000, s_d.lane_sel};
        end
      end
    end
    // Sequencer: one processor word in flight at a time; the caller holds
    // its request until ready is seen, so nothing is queued here.
    case (s_q.st)
      emb_pkg::EMB_IDLE: begin
        // Rate change is applied only while no access is in flight.
        s_d.div_applied = s_q.div_sel;
        if (cpu_req_i && s_q.ready) begin
          // Latch the whole request so later port changes cannot leak in.
          // Read data starts cleared: an unselected byte reads as zero.
          s_d.st        = emb_pkg::EMB_ISSUE;
          s_d.ready     = 1'b0;
          s_d.acc_req   = 1'b1;
          s_d.acc_we    = cpu_we_i;
          s_d.acc_reg   = cpu_is_reg_i;
          s_d.narrow    = narrow;
          s_d.rdata     = 16'h0000;
          s_d.low_wdata = {8'h00, cpu_wdata_i[7:0]};
          s_d.two_step  = 1'b0;
          if (narrow) begin
            // Byte-wide bus: data always travels on the low lane.
            s_d.acc_be = emb_pkg::BE_LOW;
            if (mode == emb_pkg::LANE_LOW) begin
              s_d.acc_hi    = 1'b0;
              s_d.acc_wdata = {8'h00, cpu_wdata_i[7:0]};
            end else begin
              s_d.acc_hi    = 1'b1;
              s_d.acc_wdata = {8'h00, cpu_wdata_i[15:8]};
              s_d.two_step  = (mode == emb_pkg::LANE_WORD);
            end
          end else begin
            // Register or word-wide bus: one access on the chosen lanes.
            s_d.acc_be    = be;
            s_d.acc_hi    = (mode == emb_pkg::LANE_HIGH);
            s_d.acc_wdata = cpu_wdata_i & mask;
          end
        end
      end
      emb_pkg::EMB_ISSUE: begin
        if (acc_ack_i) begin
          s_d.acc_req = 1'b0;
          // Wide path masks the answer; a byte bus fills one half per step.
          if (!s_q.narrow) begin
            s_d.rdata = acc_rdata_i & {{8{s_q.acc_be[1]}},
                                       {8{s_q.acc_be[0]}}};
          end else if (s_q.acc_hi) begin
            s_d.rdata[15:8] = acc_rdata_i[7:0];
          end else begin
            s_d.rdata[7:0] = acc_rdata_i[7:0];
          end
          if (s_q.two_step) begin
            // Second half of a split word: the low byte.
            s_d.two_step  = 1'b0;
            s_d.acc_req   = 1'b1;
            s_d.acc_hi    = 1'b0;
            s_d.acc_wdata = s_q.low_wdata;
          end else begin
            s_d.st    = emb_pkg::EMB_IDLE;
            s_d.ready = 1'b1;
            s_d.done  = 1'b1;
          end
        end
      end
      // An illegal state code recovers to idle and ready.
      default: begin
        s_d.st    = emb_pkg::EMB_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
  end

  // Reset leaves full rate selected and the whole-word lane mode active.
  // State register.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q             <= '0;
      s_q.hready      <= 1'b1;
      s_q.div_sel     <= emb_pkg::DIV_SEL_RST;
      s_q.div_applied <= emb_pkg::DIV_SEL_RST;
      s_q.lane_sel    <= emb_pkg::LANE_SEL_RST;
      s_q.st          <= emb_pkg::EMB_IDLE;
      s_q.ready       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // The divider sees only the applied rate, so a write landing mid-access
  // cannot shorten an enable pulse that the engines rely on.
  // Interface clock enable paces the memory engines in every mode.
  emb_clk_div u_div (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .full_rate_i (s_q.div_applied),
    .en_o        (mem_clk_en_o)
  );

  // Zero wait states: hready is held high and every answer is OKAY.
  // Outputs straight from the state register, except hresp_o, which is tied low.
  assign hreadyout_o = s_q.hready;
  assign hrdata_o    = s_q.hrdata;
  assign hresp_o     = 1'b0;
  assign cpu_ready_o = s_q.ready;
  assign cpu_done_o  = s_q.done;
  assign cpu_rdata_o = s_q.rdata;
  assign acc_req_o   = s_q.acc_req;
  assign acc_we_o    = s_q.acc_we;
  assign acc_reg_o   = s_q.acc_reg;
  assign acc_be_o    = s_q.acc_be;
  assign acc_hi_o    = s_q.acc_hi;
  assign acc_wdata_o = s_q.acc_wdata;
  assign full_rate_o = s_q.div_applied;

endmodule
`default_nettype wire

// [emb_ctrl_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module emb_ctrl_asserts (
  // Clock and reset.
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  // Watched ports.
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  input wire logic       cpu_req_i,
  input wire logic       cpu_ready_o,
  input wire logic       cpu_done_o,
  input wire logic [1:0] external_bus_width_i,
  input wire logic       acc_req_o,
  input wire logic       acc_reg_o,
  input wire logic [1:0] acc_be_o,
  input wire logic       acc_ack_i,
  input wire logic       mem_clk_en_o,
  input wire logic       full_rate_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Rate, lane and handshake relations.
  chk_full_rate_en: assert property (
    full_rate_o && $past(full_rate_o) |-> mem_clk_en_o) else $error("en low");
  chk_half_rate_en: assert property (
    (!full_rate_o)[*3] |-> mem_clk_en_o != $past(mem_clk_en_o))
    else $error("en not halved");
  chk_rate_idle: assert property (
    $changed(full_rate_o) |-> $past(cpu_ready_o) && !$past(acc_req_o))
    else $error("rate changed busy");
  chk_narrow_be: assert property (
    acc_req_o && !acc_reg_o && external_bus_width_i == 2'h0
    |-> acc_be_o == 2'h1)
    else $error("narrow lane");
  chk_issue_cause: assert property (
    $rose(acc_req_o) |-> $past(cpu_req_i && cpu_ready_o))
    else $error("stray access");
  chk_done_ack: assert property (
    cpu_done_o |-> $past(acc_ack_i)) else $error("early done");
  chk_accept_issue: assert property (
    cpu_req_i && cpu_ready_o |=> acc_req_o && !cpu_ready_o)
    else $error("no issue");
  chk_bus_okay: assert property (
    hreadyout_o && !hresp_o) else $error("bus stall");
endmodule
bind emb_ctrl emb_ctrl_asserts u_chk (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .cpu_req_i(cpu_req_i), .cpu_ready_o(cpu_ready_o), .cpu_done_o(cpu_done_o),
  .external_bus_width_i(external_bus_width_i), .acc_req_o(acc_req_o),
  .acc_reg_o(acc_reg_o),
  .acc_be_o(acc_be_o), .acc_ack_i(acc_ack_i), .mem_clk_en_o(mem_clk_en_o),
  .full_rate_o(full_rate_o));
`default_nettype wire

// [emb_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
module emb_engine_model (
  // Clock, reset and access.
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        acc_req_i,
  input  wire logic [1:0]  acc_be_i,
  input  wire logic [15:0] acc_wdata_i,
  input  wire logic [3:0]  delay_i,
  // Answer and records.
  output logic             acc_ack_o,
  output logic [15:0]      acc_rdata_o,
  output logic [1:0]       last_be_o,
  output logic [15:0]      last_wdata_o,
  output logic [7:0]       acks_o
);
  logic [3:0] wait_q;
  // Acks a held request after delay_i cycles; data toggles when idle.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {acc_ack_o, wait_q, acks_o, last_be_o, last_wdata_o} <= '0;
      acc_rdata_o <= 16'h0;
    end else if (acc_req_i && !acc_ack_o && wait_q >= delay_i) begin
      acc_ack_o <= 1'b1;
      acc_rdata_o <= 16'hc35a;
      wait_q <= 4'h0;
      acks_o <= acks_o + 8'h1;
      last_be_o <= acc_be_i;
      last_wdata_o <= acc_wdata_i;
    end else begin
      acc_ack_o <= 1'b0;
      acc_rdata_o <= ~acc_rdata_o;
      wait_q <= (acc_req_i && !acc_ack_o) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, rst_n, hsel, hwrite, hrdy, req, is_reg, we, rdy, done;
  logic acc_req, acc_ack, mclk_en, full_rate, hresp, awe, areg, ahi;
  logic [1:0] htrans, width, be, lbe;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] wd, cpu_rd, acc_wd, acc_rd, lwd;
  logic [7:0] acks, a0;
  logic [3:0] dly;
  int failures, num_checks, n;
  emb_ctrl uut (.sys_clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hready_i(hrdy), .hwdata_i(hwdata), .hreadyout_o(hrdy),
    .hrdata_o(hrdata), .hresp_o(hresp), .cpu_req_i(req),
    .cpu_is_reg_i(is_reg),
    .cpu_we_i(we), .cpu_wdata_i(wd), .cpu_ready_o(rdy), .cpu_done_o(done),
    .cpu_rdata_o(cpu_rd), .external_bus_width_i(width), .acc_req_o(acc_req),
    .acc_we_o(awe), .acc_reg_o(areg), .acc_be_o(be), .acc_hi_o(ahi),
    .acc_wdata_o(acc_wd), .acc_ack_i(acc_ack), .acc_rdata_i(acc_rd),
    .mem_clk_en_o(mclk_en), .full_rate_o(full_rate));
  emb_engine_model eng (.sys_clk_i(clk), .reset_n_i(rst_n),
    .acc_req_i(acc_req), .acc_be_i(be), .acc_wdata_i(acc_wd), .delay_i(dly),
    .acc_ack_o(acc_ack), .acc_rdata_o(acc_rd), .last_be_o(lbe),
    .last_wdata_o(lwd), .acks_o(acks));
  // Clock of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic conclude();
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  // Waits for hready (0), ready (1) or done (2) with a bound.
  task automatic wait_for(input int s);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((s == 0 ? hrdy : s == 1 ? rdy : done) !== 1'b1 && k < 99);
    if (k >= 99) begin
      failures++;
      conclude();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_for(0);
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(0);
    r = hrdata;
  endtask
  // One processor access in lane mode m on a 16- or 8-bit bus.
  task automatic cpu(input logic [1:0] m, input logic w16, input logic wr);
    logic [1:0] be_e;
    logic [15:0] mask, v, wd_e, wd_n;
    logic isr, nar;
    ahb(1'b1, emb_pkg::LANE_CTL_ADDR, {30'h0, m});
    isr = 1'($urandom);
    nar = !w16 && !isr;
    wd_n = 16'($urandom);
    be_e = nar ? 2'h1 : {m != 2'h2, m != 2'h1};
    mask = {{8{m != 2'h2}}, {8{m != 2'h1}}};
    v = nar ? 16'h5a5a : 16'hc35a;
    wd_e = nar ? {8'h0, m == 2'h1 ? wd_n[15:8] : wd_n[7:0]} : wd_n & mask;
    a0 = acks;
    width <= {1'b0, w16};
    req <= 1'b1;
    we <= wr;
    wd <= wd_n;
    is_reg <= isr;
    dly <= 4'($urandom % 4);
    wait_for(1);
    req <= 1'b0;
    wait_for(2);
    chk(32'(acks - a0), (nar && m == 2'h0) ? 32'h2 : 32'h1);
    chk(32'(lbe), 32'(be_e));
    if (!wr) chk(32'(cpu_rd), 32'(v & mask));
    if (wr) chk(32'(lwd), 32'(wd_e));
    chk(32'({awe, areg, ahi}), 32'({wr, isr, m == 2'h1}));
  endtask
  // Registers, rates and all lane modes on both bus widths.
  initial begin
    {rst_n, hsel, hwrite, req, is_reg, we} = '0;
    {htrans, haddr, hwdata, wd, dly} = '0;
    width = 2'h1;
    failures = 0;
    num_checks = 0;
    void'($urandom(99585));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b0, emb_pkg::CLK_DIV_ADDR, 0);
    chk(r, 32'h1);
    ahb(1'b0, emb_pkg::LANE_CTL_ADDR, 0);
    chk(r, 32'h0);
    ahb(1'b1, emb_pkg::LANE_CTL_ADDR, 32'hffffffff);
    ahb(1'b0, emb_pkg::LANE_CTL_ADDR, 0);
    chk(r, 32'h0);
    ahb(1'b0, 32'h100, 0);
    chk(r, 32'h0);
    chk(32'(hresp), 32'h0);
    // Half rate first, then full rate is restored.
    for (int f = 0; f < 2; f++) begin
      ahb(1'b1, emb_pkg::CLK_DIV_ADDR, {31'h7fffffff, f[0]});
      ahb(1'b0, emb_pkg::CLK_DIV_ADDR, 0);
      chk(r, 32'(f[0]));
      repeat (3) @(posedge clk);
      n = 0;
      repeat (8) begin
        @(posedge clk);
        n += mclk_en;
      end
      chk(32'(n), f ? 8 : 4);
      for (int i = 0; i < 16; i++) cpu(2'(i % 3), i[2], i[3]);
    end
    // A rate write landing mid-access waits until the access ends.
    dly <= 4'hf;
    we <= 1'b0;
    is_reg <= 1'b0;
    req <= 1'b1;
    wait_for(1);
    req <= 1'b0;
    ahb(1'b1, emb_pkg::CLK_DIV_ADDR, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'({full_rate, rdy}), 32'h2);
    wait_for(2);
    repeat (2) @(posedge clk);
    chk(32'(full_rate), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
